// file: src/rxedc_defines.vh
// Purpose: Offsets, field positions, reset values and timing counts
// Assumes: 50 MHz aclk, AXI4-Lite word registers
// Notes:   Definitions only
`ifndef RXEDC_DEFINES_VH
`define RXEDC_DEFINES_VH

// ----------------------------------------------------------------
// Register byte offsets
// ----------------------------------------------------------------
`define RXEDC_OFF_BWC      5'h00
`define RXEDC_OFF_DFE      5'h04
`define RXEDC_OFF_AGCC     5'h08
`define RXEDC_OFF_AGCS     5'h0C
`define RXEDC_OFF_EDC      5'h10
`define RXEDC_OFF_EDD      5'h14
`define RXEDC_OFF_EDV      5'h18
`define RXEDC_OFF_STAT     5'h1C

// ----------------------------------------------------------------
// Reset values
// ----------------------------------------------------------------
`define RXEDC_RST_BWC      8'h0B
`define RXEDC_RST_DFE      8'h01
`define RXEDC_RST_AGCC     8'h81
`define RXEDC_RST_AGCS     8'h77
`define RXEDC_RST_EDC      2'h0
`define RXEDC_RST_EDD      8'h01
`define RXEDC_RST_EDV      8'h7F

// ----------------------------------------------------------------
// Field positions and codes
// ----------------------------------------------------------------
`define RXEDC_GAIN_LOOP_ENABLE      0
`define RXEDC_GAIN_HOLD_CTRL    1
`define RXEDC_GAIN_HOLD_STATUS    2
`define RXEDC_GAIN_LOOP_RESET_BIT     3
`define RXEDC_GAIN_INPUT_SEL    6
`define RXEDC_BWC_IFS      4
`define RXEDC_BWC_IFI      5
`define RXEDC_DFE_RCUT_MAX 3'h4
`define RXEDC_BW_MAX       4'hB
`define RXEDC_SR_DEF       4'h1
`define RXEDC_EDM_AUTO     2'h0
`define RXEDC_EDM_SINGLE   2'h1
`define RXEDC_EDM_CONT     2'h2
`define RXEDC_EDM_OFF      2'h3
`define RXEDC_ED_INVALID   8'h7F

// ----------------------------------------------------------------
// Timing: one microsecond in clock cycles
// ----------------------------------------------------------------
`define RXEDC_CLK_MHZ      50
`define RXEDC_US_NS        1000
`define RXEDC_CLK_NS       20
`define RXEDC_CYC_PER_US   (`RXEDC_US_NS / `RXEDC_CLK_NS)

`endif

// file: src/rxedc_avg.v
// Purpose: Averages signal strength samples over one measurement period
// Assumes: Samples arrive as one-cycle strobes from the gain loop
// Notes:   Power-of-two divide not possible in general; uses sum/count

`include "rxedc_defines.vh"

module rxedc_avg #(
  parameter CNT_W = 16
) (
  input  wire             aclk,
  input  wire             aresetn,
  input  wire             start,
  input  wire             abort,
  input  wire             finish,
  input  wire             smp_vld,
  input  wire [7:0]       smp,
  output reg              res_vld_ff,
  output reg  [7:0]       res_ff
);

  reg signed [CNT_W+7:0]  sum_ff;
  reg        [CNT_W-1:0]  cnt_ff;
  reg                     run_ff;
  wire signed [CNT_W+7:0] smp_ext;
  wire signed [CNT_W+7:0] quot;

  assign smp_ext = {{CNT_W{smp[7]}}, smp};
  assign quot    = sum_ff / $signed({8'h00, cnt_ff});

  // ----------------------------------------------------------------
  // Accumulate, then divide at the period end
  // ----------------------------------------------------------------
  // average of samples
  always @(posedge aclk) begin
    if (!aresetn) begin
      sum_ff     <= {(CNT_W+8){1'b0}};
      cnt_ff     <= {CNT_W{1'b0}};
      run_ff     <= 1'b0;
      res_vld_ff <= 1'b0;
      res_ff     <= `RXEDC_ED_INVALID;
    end else begin
      res_vld_ff <= 1'b0;
      // Publish first: a continuous period ends and restarts on one edge
      if (run_ff && finish && !abort) begin
        res_vld_ff <= 1'b1;
        if (cnt_ff == {CNT_W{1'b0}}) begin
          res_ff <= `RXEDC_ED_INVALID;
        end else begin
          res_ff <= quot[7:0];
        end
      end
      if (start) begin
        sum_ff <= {(CNT_W+8){1'b0}};
        cnt_ff <= {CNT_W{1'b0}};
        run_ff <= 1'b1;
      end else if (abort || finish) begin
        run_ff <= 1'b0;
      end else if (run_ff && smp_vld && smp != `RXEDC_ED_INVALID) begin
        sum_ff <= sum_ff + smp_ext;
        cnt_ff <= cnt_ff + {{(CNT_W-1){1'b0}}, 1'b1};
      end
    end
  end

endmodule

// file: src/rxedc_top.v
// Purpose: Energy detection sequencer and receiver gain-loop settings
// Assumes: AXI4-Lite slave on aclk; rx state and baseband lines are asynchronous
// Notes:   Analogue effects appear as configuration outputs only
//
// The placing of the registers and the AXI4-Lite interface to the registers were chosen for this implementation.

`include "rxedc_defines.vh"

module rxedc_top #(
  parameter DUR_W = 24
) (
  input  wire        aclk,
  input  wire        aresetn,
  input  wire [4:0]  s_axi_awaddr,
  input  wire        s_axi_awvalid,
  output wire        s_axi_awready,
  input  wire [31:0] s_axi_wdata,
  input  wire [3:0]  s_axi_wstrb,
  input  wire        s_axi_wvalid,
  output wire        s_axi_wready,
  output reg  [1:0]  s_axi_bresp,
  output reg         s_axi_bvalid,
  input  wire        s_axi_bready,
  input  wire [4:0]  s_axi_araddr,
  input  wire        s_axi_arvalid,
  output wire        s_axi_arready,
  output reg  [31:0] s_axi_rdata,
  output reg  [1:0]  s_axi_rresp,
  output reg         s_axi_rvalid,
  input  wire        s_axi_rready,
  input  wire        rx_state_on,
  input  wire        baseband_on_bit,
  input  wire        bb_gain_hold,
  input  wire        bb_meas_cancel,
  input  wire        rssi_vld,
  input  wire [7:0]  rssi,
  output reg         energy_done_irq,
  output reg         if_invert_bit,
  output reg         if_shift_bit,
  output reg  [3:0]  filter_bandwidth_sel,
  output reg  [2:0]  cutoff_sel,
  output reg  [3:0]  sample_rate_sel,
  output reg         gain_input_sel,
  output reg  [1:0]  gain_avg_len,
  output reg         gain_loop_reset_bit,
  output reg         gain_hold_ctrl,
  output reg         gain_loop_enable,
  output reg  [2:0]  gain_target_level,
  output reg  [6:0]  gain_avg_samples
);

  // ----------------------------------------------------------------
  // Sequencer states, one-hot
  // ----------------------------------------------------------------
  localparam [2:0] ST_IDLE = 3'b001;
  localparam [2:0] ST_MEAS = 3'b010;
  localparam [2:0] ST_AUTO = 3'b100;

  reg [7:0]       bwc_ff;
  reg [7:0]       dfe_ff;
  reg [7:0]       agcc_ff;
  reg [7:0]       agcs_ff;
  reg [1:0]       edm_ff;
  reg [7:0]       edd_ff;
  reg [7:0]       edv_ff;
  reg [2:0]       st_ff;
  reg [DUR_W-1:0] tmr_ff;
  reg [1:0]       rx_sync_ff;
  reg [1:0]       bb_sync_ff;
  reg [1:0]       hold_sync_ff;
  reg [1:0]       can_sync_ff;
  reg             aw_ok_ff;
  reg             w_ok_ff;
  reg [4:0]       aw_addr_ff;
  reg [31:0]      w_data_ff;
  reg [3:0]       w_strb_ff;
  reg [DUR_W-1:0] dur_cyc;
  reg [7:0]       basis_us;
  reg [31:0]      rd_word;
  reg             rd_ok;
  reg [2:0]       nxt_st;
  wire            rx_on;
  wire            bb_on;
  wire            bb_hold;
  wire            bb_cancel;
  wire            hold_any;
  wire            wr_go;
  wire            wr_edc;
  wire            edm_wr_single;
  wire            edm_wr_cont;
  wire            period_end;
  wire            avg_vld;
  wire [7:0]      avg_res;
  wire            start_meas;
  wire            start_auto;
  wire            abort_meas;
  reg             hold_q_ff;
  reg             meas_end_ff;
  reg [31:0]      dur_full;

  // ----------------------------------------------------------------
  // Two-stage synchronisers for outside levels
  // ----------------------------------------------------------------
  always @(posedge aclk) begin
    if (!aresetn) begin
      rx_sync_ff   <= 2'b00;
      bb_sync_ff   <= 2'b00;
      hold_sync_ff <= 2'b00;
      can_sync_ff  <= 2'b00;
    end else begin
      rx_sync_ff   <= {rx_sync_ff[0], rx_state_on};
      bb_sync_ff   <= {bb_sync_ff[0], baseband_on_bit};
      hold_sync_ff <= {hold_sync_ff[0], bb_gain_hold};
      can_sync_ff  <= {can_sync_ff[0], bb_meas_cancel};
    end
  end

  assign rx_on     = rx_sync_ff[1];
  assign bb_on     = bb_sync_ff[1];
  assign bb_hold   = bb_sync_ff[1] & hold_sync_ff[1];
  assign bb_cancel = can_sync_ff[1];
  assign hold_any  = bb_hold | agcc_ff[`RXEDC_GAIN_HOLD_CTRL];

  // ----------------------------------------------------------------
  // AXI4-Lite write: address and data taken in either order
  // ----------------------------------------------------------------
  assign s_axi_awready = !aw_ok_ff && !s_axi_bvalid;
  assign s_axi_wready  = !w_ok_ff && !s_axi_bvalid;
  assign wr_go         = aw_ok_ff && w_ok_ff;
  assign wr_edc        = wr_go && aw_addr_ff == `RXEDC_OFF_EDC &&
                         w_strb_ff[0];
  assign edm_wr_single = wr_edc && w_data_ff[1:0] == `RXEDC_EDM_SINGLE;
  assign edm_wr_cont   = wr_edc && w_data_ff[1:0] == `RXEDC_EDM_CONT;

  always @(posedge aclk) begin
    if (!aresetn) begin
      aw_ok_ff     <= 1'b0;
      w_ok_ff      <= 1'b0;
      aw_addr_ff   <= 5'h00;
      w_data_ff    <= 32'h0000_0000;
      w_strb_ff    <= 4'h0;
      s_axi_bvalid <= 1'b0;
      s_axi_bresp  <= 2'b00;
    end else begin
      if (s_axi_awvalid && s_axi_awready) begin
        aw_ok_ff   <= 1'b1;
        aw_addr_ff <= {s_axi_awaddr[4:2], 2'b00};
      end
      if (s_axi_wvalid && s_axi_wready) begin
        w_ok_ff   <= 1'b1;
        w_data_ff <= s_axi_wdata;
        w_strb_ff <= s_axi_wstrb;
      end
      if (wr_go) begin
        aw_ok_ff     <= 1'b0;
        w_ok_ff      <= 1'b0;
        s_axi_bvalid <= 1'b1;
        // Offsets above EDD (the read-only EDV and STAT) answer SLVERR
        s_axi_bresp  <= (aw_addr_ff > `RXEDC_OFF_EDD) ? 2'b10 : 2'b00;
      end else if (s_axi_bvalid && s_axi_bready) begin
        s_axi_bvalid <= 1'b0;
      end
    end
  end

  // ----------------------------------------------------------------
  // Configuration registers
  // ----------------------------------------------------------------
  always @(posedge aclk) begin
    if (!aresetn) begin
      bwc_ff  <= `RXEDC_RST_BWC;
      dfe_ff  <= `RXEDC_RST_DFE;
      agcc_ff <= `RXEDC_RST_AGCC;
      agcs_ff <= `RXEDC_RST_AGCS;
      edd_ff  <= `RXEDC_RST_EDD;
    end else begin
      agcc_ff[`RXEDC_GAIN_LOOP_RESET_BIT] <= 1'b0;
      if (wr_go && w_strb_ff[0]) begin
        case (aw_addr_ff)
          `RXEDC_OFF_BWC:  bwc_ff  <= {2'b00, w_data_ff[5:0]};
          // Bit 4 of the frontend register reads zero
          `RXEDC_OFF_DFE:  dfe_ff  <= {w_data_ff[7:5], 1'b0,
                                       w_data_ff[3:0]};
          `RXEDC_OFF_AGCC: agcc_ff <= {w_data_ff[7:3], 1'b0,
                                       w_data_ff[1:0]};
          `RXEDC_OFF_AGCS: agcs_ff <= {w_data_ff[7:5], 5'h17};
          `RXEDC_OFF_EDD:  edd_ff  <= w_data_ff[7:0];
          default:         edd_ff  <= edd_ff;
        endcase
      end
    end
  end

  // ----------------------------------------------------------------
  // Field decode toward the receiver; all outputs registered
  // ----------------------------------------------------------------
  always @(posedge aclk) begin
    if (!aresetn) begin
      if_invert_bit        <= 1'b0;
      if_shift_bit         <= 1'b0;
      filter_bandwidth_sel <= `RXEDC_BW_MAX;
      cutoff_sel           <= 3'h0;
      sample_rate_sel      <= `RXEDC_SR_DEF;
      gain_input_sel       <= 1'b0;
      gain_avg_len         <= 2'h0;
      gain_avg_samples     <= 7'd8;
      gain_loop_reset_bit  <= 1'b0;
      gain_hold_ctrl       <= 1'b0;
      gain_loop_enable     <= 1'b1;
      gain_target_level    <= 3'h3;
    end else begin
      if_invert_bit        <= bwc_ff[`RXEDC_BWC_IFI];
      if_shift_bit         <= bwc_ff[`RXEDC_BWC_IFS];
      // bandwidth code, out-of-range kept at default
      filter_bandwidth_sel <= (bwc_ff[3:0] > `RXEDC_BW_MAX) ?
                              `RXEDC_BW_MAX : bwc_ff[3:0];
      cutoff_sel           <= (dfe_ff[7:5] > `RXEDC_DFE_RCUT_MAX) ?
                              3'h0 : dfe_ff[7:5];
      case (dfe_ff[3:0])
        4'h1, 4'h2, 4'h3, 4'h4, 4'h5, 4'h6, 4'h8, 4'hA:
          sample_rate_sel <= dfe_ff[3:0];
        default:
          sample_rate_sel <= `RXEDC_SR_DEF;
      endcase
      gain_input_sel       <= agcc_ff[`RXEDC_GAIN_INPUT_SEL];
      gain_avg_len         <= agcc_ff[5:4];
      gain_avg_samples     <= 7'd8 << agcc_ff[5:4];
      gain_loop_reset_bit  <= agcc_ff[`RXEDC_GAIN_LOOP_RESET_BIT];
      gain_hold_ctrl       <= hold_any;
      gain_loop_enable     <= agcc_ff[`RXEDC_GAIN_LOOP_ENABLE];
      gain_target_level    <= agcs_ff[7:5];
    end
  end

  // ----------------------------------------------------------------
  // Averaging time in cycles
  // ----------------------------------------------------------------
  // factor times basis
  always @* begin
    case (edd_ff[1:0])
      2'h0:    basis_us = 8'd2;
      2'h1:    basis_us = 8'd8;
      2'h2:    basis_us = 8'd32;
      default: basis_us = 8'd128;
    endcase
    // Longest period fits the timer, so the product is cut on purpose
    dur_full = edd_ff[7:2] * basis_us * `RXEDC_CYC_PER_US;
    dur_cyc  = dur_full[DUR_W-1:0];
  end

  // ----------------------------------------------------------------
  // Sequencer
  // ----------------------------------------------------------------
  // run only in receive, not in off mode
  assign start_meas = rx_on && (edm_wr_single || edm_wr_cont);
  assign start_auto = st_ff == ST_IDLE && rx_on && edm_ff ==
                      `RXEDC_EDM_AUTO && hold_any && !hold_q_ff;
  assign period_end = (st_ff != ST_IDLE) && tmr_ff == {DUR_W{1'b0}};
  assign abort_meas = !rx_on || (st_ff == ST_AUTO &&
                      (bb_cancel || !hold_any));

  always @* begin
    nxt_st = st_ff;
    case (st_ff)
      ST_IDLE: begin
        if (start_meas) begin
          nxt_st = ST_MEAS;
        end else if (start_auto) begin
          nxt_st = ST_AUTO;
        end
      end
      ST_MEAS: begin
        if (!rx_on || (wr_edc && !start_meas)) begin
          nxt_st = ST_IDLE;
        end else if (period_end && edm_ff != `RXEDC_EDM_CONT) begin
          nxt_st = ST_IDLE;
        end
      end
      ST_AUTO: begin
        if (start_meas) begin
          nxt_st = ST_MEAS;
        end else if (abort_meas || period_end) begin
          nxt_st = ST_IDLE;
        end
      end
      default: nxt_st = ST_IDLE;
    endcase
  end

  always @(posedge aclk) begin
    if (!aresetn) begin
      st_ff           <= ST_IDLE;
      tmr_ff          <= {DUR_W{1'b0}};
      edm_ff          <= `RXEDC_RST_EDC;
      hold_q_ff       <= 1'b0;
      meas_end_ff     <= 1'b0;
      energy_done_irq <= 1'b0;
      edv_ff          <= `RXEDC_RST_EDV;
    end else begin
      st_ff           <= nxt_st;
      hold_q_ff       <= hold_any;
      // Single is already idle when its result lands; remember the kind
      meas_end_ff     <= period_end && !abort_meas && st_ff == ST_MEAS;
      energy_done_irq <= 1'b0;
      if (nxt_st != ST_IDLE && (nxt_st != st_ff || period_end)) begin
        tmr_ff <= dur_cyc;
      end else if (tmr_ff != {DUR_W{1'b0}}) begin
        tmr_ff <= tmr_ff - {{(DUR_W-1){1'b0}}, 1'b1};
      end
      // single returns mode to automatic at its end
      if (st_ff == ST_MEAS && period_end &&
          edm_ff == `RXEDC_EDM_SINGLE) begin
        edm_ff <= `RXEDC_EDM_AUTO;
      // leaving receive in continuous restores automatic
      end else if (st_ff == ST_MEAS && !rx_on) begin
        edm_ff <= `RXEDC_EDM_AUTO;
      end else if (wr_edc) begin
        edm_ff <= w_data_ff[1:0];
      end
      if (avg_vld && meas_end_ff) begin
        edv_ff          <= avg_res;
        energy_done_irq <= 1'b1;
      // automatic result overwrites, no done pulse
      end else if (avg_vld) begin
        edv_ff <= avg_res;
      end
    end
  end

  // Averager restarts at each period so results never mix
  rxedc_avg #(
    .CNT_W (DUR_W)
  ) u_avg (
    .aclk       (aclk),
    .aresetn    (aresetn),
    .start      (nxt_st != ST_IDLE && (nxt_st != st_ff || period_end)),
    .abort      (nxt_st == ST_IDLE && !period_end),
    .finish     (period_end && !abort_meas),
    .smp_vld    (rssi_vld),
    .smp        (rssi),
    .res_vld_ff (avg_vld),
    .res_ff     (avg_res)
  );

  // ----------------------------------------------------------------
  // AXI4-Lite read
  // ----------------------------------------------------------------
  always @* begin
    rd_ok   = 1'b1;
    rd_word = 32'h0000_0000;
    case ({s_axi_araddr[4:2], 2'b00})
      `RXEDC_OFF_BWC:  rd_word[7:0] = bwc_ff;
      `RXEDC_OFF_DFE:  rd_word[7:0] = dfe_ff;
      `RXEDC_OFF_AGCC: rd_word[7:0] = {agcc_ff[7:3], hold_any,
                                       agcc_ff[1:0]};
      `RXEDC_OFF_AGCS: rd_word[7:0] = agcs_ff;
      `RXEDC_OFF_EDC:  rd_word[1:0] = edm_ff;
      `RXEDC_OFF_EDD:  rd_word[7:0] = edd_ff;
      `RXEDC_OFF_EDV:  rd_word[7:0] = edv_ff;
      `RXEDC_OFF_STAT: rd_word[3:0] = {bb_on, rx_on, st_ff[2:1] != 2'b00,
                                       st_ff[1]};
      default:         rd_ok = 1'b0;
    endcase
  end

  assign s_axi_arready = !s_axi_rvalid;

  always @(posedge aclk) begin
    if (!aresetn) begin
      s_axi_rvalid <= 1'b0;
      s_axi_rdata  <= 32'h0000_0000;
      s_axi_rresp  <= 2'b00;
    end else if (s_axi_arvalid && s_axi_arready) begin
      s_axi_rvalid <= 1'b1;
      s_axi_rdata  <= rd_word;
      s_axi_rresp  <= rd_ok ? 2'b00 : 2'b10;
    end else if (s_axi_rvalid && s_axi_rready) begin
      s_axi_rvalid <= 1'b0;
    end
  end

endmodule

// file: verif/rxedc_rssi_src.sv
// Purpose: Signal strength sample source facing the energy sequencer
// Assumes: One sample every fourth cycle at the level the bench sets
// Notes:   Between strobes the data lines show the inverted level
module rxedc_rssi_src (
  input  wire logic       aclk,
  input  wire logic       aresetn,
  input  wire logic [7:0] lvl,
  output logic            rssi_vld,
  output logic [7:0]      rssi
);
  timeunit 1ns;
  timeprecision 1ps;
  logic [1:0] ph_ff;
  // in-range dBm samples
  // Idle data is inverted so a stale sample never passes unnoticed
  always @(posedge aclk) begin
    ph_ff <= aresetn ? ph_ff + 2'h1 : 2'h0;
    rssi_vld <= aresetn && ph_ff == 2'h3;
    rssi <= (aresetn && ph_ff == 2'h3) ? lvl : ~lvl;
  end
endmodule

// file: verif/rxedc_top_assertions.sv
// Purpose: Port-level checks on the energy sequencer and gain settings
// Assumes: Synchronous active-low reset on aclk
// Notes:   Bound to every instance of the top module
module rxedc_top_chk (
  input wire logic       aclk, aresetn, energy_done_irq,
  input wire logic       s_axi_bvalid, s_axi_bready, s_axi_rvalid,
  input wire logic       s_axi_rready, s_axi_arvalid, s_axi_arready,
  input wire logic       gain_loop_reset_bit, gain_loop_enable,
  input wire logic [1:0] gain_avg_len,
  input wire logic [6:0] gain_avg_samples,
  input wire logic [3:0] filter_bandwidth_sel, sample_rate_sel,
  input wire logic [2:0] cutoff_sel, gain_target_level
);
  timeunit 1ns;
  timeprecision 1ps;
  property p_done_pulse;
    @(posedge aclk) disable iff (!aresetn)
    energy_done_irq |=> !energy_done_irq;
  endproperty
  a_done_pulse: assert property (p_done_pulse)
    else $error("done pulse longer than one cycle");
  property p_rst_cfg;
    @(posedge aclk) !aresetn |=> filter_bandwidth_sel == 4'hB
      && cutoff_sel == 3'h0 && sample_rate_sel == 4'h1;
  endproperty
  a_rst_cfg: assert property (p_rst_cfg)
    else $error("filter settings wrong after reset");
  property p_rst_gain;
    @(posedge aclk) !aresetn |=> gain_loop_enable
      && gain_target_level == 3'h3;
  endproperty
  a_rst_gain: assert property (p_rst_gain)
    else $error("gain settings wrong after reset");
  property p_rst_self_clear;
    @(posedge aclk) disable iff (!aresetn)
    gain_loop_reset_bit |=> !gain_loop_reset_bit;
  endproperty
  a_rst_self_clear: assert property (p_rst_self_clear)
    else $error("gain reset command did not clear");
  property p_avg_len;
    @(posedge aclk) disable iff (!aresetn)
    gain_avg_samples == (7'h08 << gain_avg_len);
  endproperty
  a_avg_len: assert property (p_avg_len)
    else $error("averaging sample count wrong");
  property p_b_stands;
    @(posedge aclk) disable iff (!aresetn)
    s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid;
  endproperty
  a_b_stands: assert property (p_b_stands)
    else $error("write response dropped");
  property p_r_stands;
    @(posedge aclk) disable iff (!aresetn)
    s_axi_rvalid && !s_axi_rready |=> $stable(s_axi_rvalid);
  endproperty
  a_r_stands: assert property (p_r_stands)
    else $error("read response dropped");
  property p_r_answer;
    @(posedge aclk) disable iff (!aresetn)
    s_axi_arvalid && s_axi_arready |=> s_axi_rvalid;
  endproperty
  a_r_answer: assert property (p_r_answer)
    else $error("read answer late");
endmodule
bind rxedc_top rxedc_top_chk i_chk (.*);

// file: verif/tb.sv
// Purpose: Register and measurement tests of the energy sequencer
// Assumes: AXI4-Lite master tasks, single outstanding access
// Notes:   Baseband cancel line is tied off
module tb;
  timeunit 1ns;
  timeprecision 1ps;
  logic aclk = 0, aresetn = 0, awv = 0, wv = 0, bry = 0, arv = 0, rry = 0;
  logic [4:0] awa = 5'h00, ara = 5'h00;
  logic [31:0] wd = 32'h0, rd, rdata;
  logic [1:0] br, bresp, rresp;
  logic awr, wr, bv, arr, rv, done, vld, rx = 0, bbon = 0, bbh = 0;
  logic [7:0] lvl = 8'hCE, rs;
  logic [6:0] smp;
  logic [3:0] bw, sr;
  logic [2:0] cut, tgt;
  logic [1:0] avl;
  logic ifi, ifs, gis, grst, ghc, gen;
  int fails = 0, samples_checked = 0, cyc = 0, n;
  always #10 aclk = ~aclk;
  rxedc_rssi_src i_src (.aclk(aclk), .aresetn(aresetn), .lvl(lvl),
    .rssi_vld(vld), .rssi(rs));
  rxedc_top i_dut (.aclk(aclk), .aresetn(aresetn), .s_axi_awaddr(awa),
    .s_axi_awvalid(awv), .s_axi_awready(awr), .s_axi_wdata(wd),
    .s_axi_wstrb(4'hF), .s_axi_wvalid(wv), .s_axi_wready(wr),
    .s_axi_bresp(bresp), .s_axi_bvalid(bv), .s_axi_bready(bry),
    .s_axi_araddr(ara), .s_axi_arvalid(arv), .s_axi_arready(arr),
    .s_axi_rdata(rdata), .s_axi_rresp(rresp), .s_axi_rvalid(rv),
    .s_axi_rready(rry), .rx_state_on(rx), .baseband_on_bit(bbon),
    .bb_gain_hold(bbh), .bb_meas_cancel(1'b0), .rssi_vld(vld),
    .rssi(rs), .energy_done_irq(done), .if_invert_bit(ifi),
    .if_shift_bit(ifs), .filter_bandwidth_sel(bw), .cutoff_sel(cut),
    .sample_rate_sel(sr), .gain_input_sel(gis), .gain_avg_len(avl),
    .gain_loop_reset_bit(grst), .gain_hold_ctrl(ghc),
    .gain_loop_enable(gen), .gain_target_level(tgt),
    .gain_avg_samples(smp));
  task automatic check(input logic [31:0] s, e, input string nm);
    samples_checked++;
    if (s !== e) begin
      fails++;
      $display("ERROR %s expected %h seen %h", nm, e, s);
    end
  endtask
  // Address and data offered together, each dropped once taken
  task automatic wr32(input logic [4:0] a, input logic [7:0] d);
    @(posedge aclk);
    awa <= a; wd <= {24'h0, d}; awv <= 1; wv <= 1; bry <= 1;
    do begin
      @(posedge aclk);
      if (awr) awv <= 0;
      if (wr) wv <= 0;
    end while (bv !== 1'b1);
    br = bresp;
    bry <= 0;
  endtask
  task automatic rd32(input logic [4:0] a);
    @(posedge aclk);
    ara <= a; arv <= 1; rry <= 1;
    do begin
      @(posedge aclk);
      if (arr) arv <= 0;
    end while (rv !== 1'b1);
    rd = rdata;
    rry <= 0;
  endtask
  task automatic rdchk(input logic [4:0] a, input logic [7:0] e);
    rd32(a);
    check(rd, {24'h0, e}, "register");
  endtask
  task automatic settle(input int c);
    repeat (c) @(posedge aclk);
    #1;
  endtask
  task automatic wait_done;
    n = 0;
    do begin
      @(posedge aclk);
      #1;
      n++;
    end while (done !== 1'b1 && n < 2000);
    check(done, 1, "done pulse");
  endtask
  task automatic wrap_up;
    $display("checks %0d mismatches %0d", samples_checked, fails);
    if (fails == 0 && samples_checked > 0) $display("All tests passed");
    else $display("Some tests failed");
    $finish;
  endtask
  // Watchdog on the whole run
  always @(posedge aclk) begin
    cyc++;
    if (cyc == 20000) begin
      fails++;
      wrap_up();
    end
  end
  initial begin
    repeat (2) @(posedge aclk);
    aresetn <= 1;
    rdchk(5'h00, 8'h0B);
    rdchk(5'h04, 8'h01);
    rdchk(5'h08, 8'h81);
    rdchk(5'h0C, 8'h77);
    rdchk(5'h14, 8'h01);
    rdchk(5'h18, 8'h7F);
    rdchk(5'h10, 8'h00);
    $display("test reset done");
    wr32(5'h00, 8'h35); wr32(5'h04, 8'h87); settle(2);
    check({ifi, ifs, bw}, 6'h35, "bw ctrl");
    check({cut, sr}, 7'h41, "frontend");
    wr32(5'h08, 8'h71); settle(2);
    check({gis, avl, gen}, 4'hF, "gain ctrl");
    check(smp, 7'h40, "avg samples");
    wr32(5'h08, 8'h09);
    #1;
    check(grst, 1, "gain reset pulse");
    settle(2);
    rdchk(5'h08, 8'h01);
    wr32(5'h08, 8'h03); settle(2);
    check(ghc, 1, "hold");
    rdchk(5'h08, 8'h07);
    wr32(5'h08, 8'h00); settle(2);
    check({ghc, gen}, 2'h0, "release");
    wr32(5'h0C, 8'hE0); settle(2);
    check(tgt, 3'h7, "target");
    rdchk(5'h0C, 8'hF7);
    wr32(5'h18, 8'h00);
    check(br, 2'h2, "slverr");
    rdchk(5'h18, 8'h7F);
    $display("test registers done");
    rx <= 1; wr32(5'h14, 8'h04); settle(4);
    wr32(5'h10, 8'h01); wait_done();
    rdchk(5'h18, 8'hCE);
    rdchk(5'h10, 8'h00);
    $display("test single done");
    wr32(5'h10, 8'h02); wait_done();
    lvl <= 8'hC4; wait_done(); wait_done();
    rdchk(5'h18, 8'hC4);
    wr32(5'h10, 8'h00); n = 0;
    repeat (300) begin
      @(posedge aclk);
      if (done === 1'b1) n++;
    end
    check(n, 0, "stopped");
    wr32(5'h10, 8'h02); wait_done();
    rx <= 0; settle(8);
    rdchk(5'h10, 8'h00);
    $display("test continuous done");
    // Baseband hold in receive starts an automatic period
    rx <= 1; lvl <= 8'hD0; bbon <= 1; bbh <= 1; settle(6);
    check(ghc, 1, "bb hold");
    rdchk(5'h08, 8'h04);
    rdchk(5'h1C, 8'h0E);
    n = 0;
    repeat (120) begin
      @(posedge aclk);
      if (done === 1'b1) n++;
    end
    check(n, 0, "auto no done");
    rdchk(5'h18, 8'hD0);
    $display("test baseband done");
    wrap_up();
  end
endmodule
